// [hw/fct_pkg.sv]
/*
  Shared constants for the four counter/timer set: mode codes, clock source
  codes, prescale encodings and division ratios.
  Assumes one system clock domain; all other inputs are synchronous or are
  synchronised by the block itself.
*/
package fct_pkg;

  // ****************************************************************
  // Timer 0/1 operating modes.
  // ****************************************************************
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_8BIT_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // ****************************************************************
  // Prescale select encodings for the Timer 0/1 shared prescaler.
  // ****************************************************************
  localparam logic [1:0] PRESCALE_DIV12 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
  localparam logic [1:0] PRESCALE_DIV48 = 2'h2;
  localparam logic [1:0] PRESCALE_EXT8 = 2'h3;

  // ****************************************************************
  // Timer 2/3 external clock source encodings.
  // ****************************************************************
  localparam logic [1:0] XCLK_DIV12 = 2'h0;
  localparam logic [1:0] XCLK_SLOW8 = 2'h1;
  localparam logic [1:0] XCLK_CMP = 2'h2;

  // ****************************************************************
  // Division ratios.
  // ****************************************************************
  localparam logic [5:0] DIV_12 = 6'h0C;
  localparam logic [5:0] DIV_4 = 6'h04;
  localparam logic [5:0] DIV_48 = 6'h30;
  localparam logic [5:0] DIV_8 = 6'h08;

  // ****************************************************************
  // Edge detector state width and 13-bit count mask.
  // ****************************************************************
  localparam int SYNC_STAGES = 2;
  localparam logic [12:0] MASK_13 = 13'h1FFF;

endpackage : fct_pkg

// [hw/fct_edge_sync.sv]
/*
  Two-flop synchroniser followed by a falling edge detector.
  Assumes the input holds each level for at least two clock periods.
*/
`timescale 1ns/1ps
`default_nettype none
module fct_edge_sync (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic async_in,
  output logic level,
  output logic fall
);

  logic stage1;
  logic stage2;
  logic prev;
  logic next_stage1;
  logic next_stage2;
  logic next_prev;

  // ****************************************************************
  // Synchroniser and edge detector.
  // ****************************************************************

  // Next values: the first stage is read only by the second.
  always_comb begin
    next_stage1 = async_in;
    next_stage2 = stage1;
    next_prev = stage2;
  end

  // Registers the chain; idles high so reset makes no false edge.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1 <= 1'h1;
      stage2 <= 1'h1;
      prev <= 1'h1;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      prev <= next_prev;
    end
  end

  assign level = stage2;
  assign fall = prev & ~stage2;

endmodule : fct_edge_sync
`default_nettype wire

// [hw/fct_divider.sv]
/*
  Tick generator: one-cycle pulse every ratio input strobes.
  Assumes ratio is at least 1 and changes only rarely.
*/
`timescale 1ns/1ps
`default_nettype none
module fct_divider (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic strobe,
  input wire logic [5:0] ratio,
  output logic tick
);

  logic [5:0] count;
  logic [5:0] next_count;

  // Counts strobes and wraps at the ratio.
  always_comb begin
    next_count = count;
    if (strobe) begin
      if (count >= ratio - 6'h01) begin
        next_count = 6'h00;
      end else begin
        next_count = count + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count <= 6'h00;
    end else begin
      count <= next_count;
    end
  end

  assign tick = strobe && (count >= ratio - 6'h01);

endmodule : fct_divider
`default_nettype wire

// [hw/fct_timers.sv]
/*
  Four counter/timers: Timers 0 and 1 with four modes and event counting,
  Timers 2 and 3 with 16-bit or split auto-reload and capture.
  Assumes software loads counts through the load ports, and that slow
  clocks and comparator levels arrive as asynchronous levels.
*/
`timescale 1ns/1ps
`default_nettype none
module fct_timers (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [1:0] prescale_select,
  input wire logic timer0_clock_select,
  input wire logic timer1_clock_select,
  input wire logic [1:0] mode_0,
  input wire logic [1:0] mode_1,
  input wire logic counter_select_0,
  input wire logic counter_select_1,
  input wire logic run_control_0,
  input wire logic run_control_1,
  input wire logic gate_enable_0,
  input wire logic gate_enable_1,
  input wire logic external_gate_input_0,
  input wire logic external_gate_input_1,
  input wire logic event_input_0,
  input wire logic event_input_1,
  input wire logic ext_osc_clk,
  input wire logic rtc_clk,
  input wire logic comparator_0,
  input wire logic comparator_1,
  input wire logic load_0,
  input wire logic load_1,
  input wire logic [15:0] load_value_0,
  input wire logic [15:0] load_value_1,
  input wire logic [1:0] run_control_hi,
  input wire logic [1:0] run_control_23,
  input wire logic [1:0] split_23,
  input wire logic [1:0] capture_23,
  input wire logic [1:0] sysclk_lo_23,
  input wire logic [1:0] sysclk_hi_23,
  input wire logic [3:0] xclk_23,
  input wire logic [1:0] load_23,
  input wire logic [31:0] load_count_23,
  input wire logic [1:0] load_reload_23,
  input wire logic [31:0] reload_value_23,
  output logic [15:0] count_0,
  output logic [15:0] count_1,
  output logic overflow_0,
  output logic overflow_1,
  output logic [31:0] count_23,
  output logic [31:0] reload_23,
  output logic [1:0] overflow_lo_23,
  output logic [1:0] overflow_hi_23
);

  // ****************************************************************
  // Synchronisers for event inputs and slow clock sources.
  // ****************************************************************
  logic [5:0] async_src;
  logic [5:0] sync_fall;

  assign async_src = {comparator_1, comparator_0, rtc_clk, ext_osc_clk, event_input_1,
                      event_input_0};

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gen_sync
      fct_edge_sync u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(async_src[g]),
        .level(),
        .fall(sync_fall[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Dividers for prescaled and slow clocks.
  // ****************************************************************
  logic [5:0] pre_ratio;
  logic pre_tick;
  logic div12_tick;
  logic rtc8_tick;
  logic osc8_tick;

  // Shared prescaler ratio and input strobe.
  always_comb begin
    case (prescale_select)
      fct_pkg::PRESCALE_DIV12: pre_ratio = fct_pkg::DIV_12;
      fct_pkg::PRESCALE_DIV4: pre_ratio = fct_pkg::DIV_4;
      fct_pkg::PRESCALE_DIV48: pre_ratio = fct_pkg::DIV_48;
      default: pre_ratio = fct_pkg::DIV_8;
    endcase
  end

  fct_divider u_pre (
    .core_clk(core_clk),
    .srst(srst),
    .strobe((prescale_select == fct_pkg::PRESCALE_EXT8) ? sync_fall[2] : 1'h1),
    .ratio(pre_ratio),
    .tick(pre_tick)
  );

  fct_divider u_div12 (
    .core_clk(core_clk),
    .srst(srst),
    .strobe(1'h1),
    .ratio(fct_pkg::DIV_12),
    .tick(div12_tick)
  );

  fct_divider u_rtc8 (
    .core_clk(core_clk),
    .srst(srst),
    .strobe(sync_fall[3]),
    .ratio(fct_pkg::DIV_8),
    .tick(rtc8_tick)
  );

  fct_divider u_osc8 (
    .core_clk(core_clk),
    .srst(srst),
    .strobe(sync_fall[2]),
    .ratio(fct_pkg::DIV_8),
    .tick(osc8_tick)
  );

  // ****************************************************************
  // Timer 0 and Timer 1.
  // ****************************************************************
  logic [1:0] inc01;
  logic inc_hi0;
  logic [15:0] next_count_0;
  logic [15:0] next_count_1;
  logic next_overflow_0;
  logic next_overflow_1;

  // Works out one step of a classic timer in the given mode.
  function automatic logic [16:0] step01(input logic [1:0] mode, input logic [15:0] cnt);
    logic [12:0] c13;
    logic [7:0] lo;
    c13 = {cnt[15:8], cnt[4:0]} + 13'h0001;
    lo = cnt[7:0] + 8'h01;
    case (mode)
      fct_pkg::MODE_13BIT: step01 = {(c13 == 13'h0000), c13[12:5], cnt[7:5], c13[4:0]};
      fct_pkg::MODE_16BIT: step01 = {(cnt == 16'hFFFF), cnt + 16'h0001};
      fct_pkg::MODE_8BIT_RELOAD: step01 = (cnt[7:0] == 8'hFF) ?
                                          {1'h1, cnt[15:8], cnt[15:8]} : {1'h0, cnt[15:8], lo};
      default: step01 = {(cnt[7:0] == 8'hFF), cnt[15:8], lo};
    endcase
  endfunction : step01

  // Increment conditions: clock choice, event counting and gating.
  always_comb begin
    inc01[0] = run_control_0 && (!gate_enable_0 || external_gate_input_0) &&
               (counter_select_0 ? sync_fall[0] :
                (timer0_clock_select ? 1'h1 : pre_tick));
    inc01[1] = run_control_1 && (!gate_enable_1 || external_gate_input_1) &&
               (counter_select_1 ? sync_fall[1] :
                (timer1_clock_select ? 1'h1 : pre_tick));
    // Split mode high byte of Timer 0 is a timer on run_control_hi[0].
    inc_hi0 = (mode_0 == fct_pkg::MODE_SPLIT) && run_control_hi[0] &&
              (timer0_clock_select ? 1'h1 : pre_tick);
  end

  // Next values of Timer 0 and Timer 1; a load wins over counting.
  always_comb begin
    logic [16:0] s0;
    logic [16:0] s1;
    logic [7:0] hi;
    s0 = step01(mode_0, count_0);
    s1 = step01((mode_1 == fct_pkg::MODE_SPLIT) ? fct_pkg::MODE_16BIT : mode_1, count_1);
    hi = count_0[15:8] + 8'h01;
    next_count_0 = count_0;
    next_count_1 = count_1;
    next_overflow_0 = 1'h0;
    next_overflow_1 = 1'h0;
    if (inc01[0]) begin
      next_count_0 = s0[15:0];
      next_overflow_0 = s0[16];
    end
    if (inc_hi0) begin
      next_count_0[15:8] = hi;
      next_overflow_1 = (count_0[15:8] == 8'hFF);
    end
    if (inc01[1] && mode_1 != fct_pkg::MODE_SPLIT) begin
      next_count_1 = s1[15:0];
      next_overflow_1 = s1[16];
    end
    if (load_0) begin
      next_count_0 = load_value_0;
    end
    if (load_1) begin
      next_count_1 = load_value_1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_0 <= 16'h0000;
      count_1 <= 16'h0000;
      overflow_0 <= 1'h0;
      overflow_1 <= 1'h0;
    end else begin
      count_0 <= next_count_0;
      count_1 <= next_count_1;
      overflow_0 <= next_overflow_0;
      overflow_1 <= next_overflow_1;
    end
  end

  // ****************************************************************
  // Timer 2 and Timer 3.
  // ****************************************************************
  logic [31:0] next_count_23;
  logic [31:0] next_reload_23;
  logic [1:0] next_ovf_lo;
  logic [1:0] next_ovf_hi;
  logic [1:0] xtick;
  logic [1:0] cap_edge;

  // Selected external clock and capture edge for each timer.
  always_comb begin
    case (xclk_23[1:0])
      fct_pkg::XCLK_DIV12: xtick[0] = div12_tick;
      fct_pkg::XCLK_SLOW8: xtick[0] = rtc8_tick;
      fct_pkg::XCLK_CMP: xtick[0] = sync_fall[4];
      default: xtick[0] = div12_tick;
    endcase
    case (xclk_23[3:2])
      fct_pkg::XCLK_DIV12: xtick[1] = div12_tick;
      fct_pkg::XCLK_SLOW8: xtick[1] = osc8_tick;
      fct_pkg::XCLK_CMP: xtick[1] = sync_fall[5];
      default: xtick[1] = div12_tick;
    endcase
    cap_edge[0] = (xclk_23[1:0] == fct_pkg::XCLK_CMP) ? sync_fall[4] : rtc8_tick;
    cap_edge[1] = (xclk_23[3:2] == fct_pkg::XCLK_CMP) ? sync_fall[5] : osc8_tick;
  end

  // Per-timer count, reload, split and capture behaviour.
  always_comb begin
    next_count_23 = count_23;
    next_reload_23 = reload_23;
    next_ovf_lo = 2'h0;
    next_ovf_hi = 2'h0;
    for (int i = 0; i < 2; i++) begin
      logic [15:0] c;
      logic [15:0] r;
      logic lo_inc;
      logic hi_inc;
      c = count_23[16*i +: 16];
      r = reload_23[16*i +: 16];
      lo_inc = run_control_23[i] && (sysclk_lo_23[i] ? 1'h1 : xtick[i]);
      hi_inc = run_control_23[i] && (sysclk_hi_23[i] ? 1'h1 : xtick[i]);
      if (capture_23[i]) begin
        // Capture mode counts system clocks or the selected external clock, latching on edges.
        if (lo_inc) begin
          c = c + 16'h0001;
        end
        if (run_control_23[i] && cap_edge[i]) begin
          r = count_23[16*i +: 16];
          next_ovf_hi[i] = 1'h1;
        end
      end else if (split_23[i]) begin
        if (lo_inc) begin
          c[7:0] = (c[7:0] == 8'hFF) ? r[7:0] : c[7:0] + 8'h01;
          next_ovf_lo[i] = (count_23[16*i +: 8] == 8'hFF);
        end
        if (hi_inc) begin
          c[15:8] = (c[15:8] == 8'hFF) ? r[15:8] : c[15:8] + 8'h01;
          next_ovf_hi[i] = (count_23[16*i+8 +: 8] == 8'hFF);
        end
      end else if (lo_inc) begin
        c = (c == 16'hFFFF) ? r : c + 16'h0001;
        next_ovf_hi[i] = (count_23[16*i +: 16] == 16'hFFFF);
      end
      if (load_23[i]) begin
        c = load_count_23[16*i +: 16];
      end
      if (load_reload_23[i]) begin
        r = reload_value_23[16*i +: 16];
      end
      next_count_23[16*i +: 16] = c;
      next_reload_23[16*i +: 16] = r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_23 <= 32'h00000000;
      reload_23 <= 32'h00000000;
      overflow_lo_23 <= 2'h0;
      overflow_hi_23 <= 2'h0;
    end else begin
      count_23 <= next_count_23;
      reload_23 <= next_reload_23;
      overflow_lo_23 <= next_ovf_lo;
      overflow_hi_23 <= next_ovf_hi;
    end
  end

endmodule : fct_timers
`default_nettype wire

// [verification/fct_checker.sv]
/*
  Checker for the four counter/timer set, bound to the top module ports.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module fct_checker (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [1:0] mode_0,
  input wire logic counter_select_0,
  input wire logic timer0_clock_select,
  input wire logic run_control_0,
  input wire logic gate_enable_0,
  input wire logic external_gate_input_0,
  input wire logic event_input_0,
  input wire logic load_0,
  input wire logic [15:0] count_0,
  input wire logic overflow_0,
  input wire logic [1:0] run_control_23,
  input wire logic [1:0] split_23,
  input wire logic [1:0] capture_23,
  input wire logic [1:0] sysclk_lo_23,
  input wire logic [1:0] load_23,
  input wire logic [1:0] load_reload_23,
  input wire logic [31:0] count_23,
  input wire logic [31:0] reload_23
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // Enable terms shared by several properties.
  wire logic run0 = run_control_0 && (!gate_enable_0 || external_gate_input_0);
  wire logic sys0 = run0 && !counter_select_0 && timer0_clock_select && !load_0;
  wire logic t2sys = run_control_23[0] && sysclk_lo_23[0] && !split_23[0] && !capture_23[0]
    && !load_23[0];
  wire logic [15:0] t2 = count_23[15:0];

  property p_hold0;
    !run0 && !load_0 && mode_0 != fct_pkg::MODE_SPLIT |=> count_0 == $past(count_0);
  endproperty
  a_hold0: assert property (p_hold0) else $error("Timer 0 moved while stopped.");
  property p_sys16;
    sys0 && mode_0 == fct_pkg::MODE_16BIT |=> count_0 == $past(count_0) + 16'h1;
  endproperty
  a_sys16: assert property (p_sys16) else $error("Timer 0 missed a clock.");
  property p_wrap13;
    sys0 && mode_0 == fct_pkg::MODE_13BIT && count_0[15:8] == 8'hFF && count_0[4:0] == 5'h1F
      |=> (count_0[15:8] == 8'h00 && count_0[4:0] == 5'h00) ##[0:1] overflow_0;
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("Bad 13-bit wrap.");
  property p_upper13;
    mode_0 == fct_pkg::MODE_13BIT && !load_0 |=> $stable(count_0[7:5]);
  endproperty
  a_upper13: assert property (p_upper13) else $error("Unused bits moved.");
  property p_reload8;
    sys0 && mode_0 == fct_pkg::MODE_8BIT_RELOAD && count_0[7:0] == 8'hFF
      |=> count_0[7:0] == count_0[15:8] && $stable(count_0[15:8]);
  endproperty
  a_reload8: assert property (p_reload8) else $error("Bad 8-bit reload.");
  property p_event;
    $fell(event_input_0) && counter_select_0 && run0 && !load_0
      && mode_0 == fct_pkg::MODE_16BIT |-> ##[1:4] count_0 == $past(count_0) + 16'h1;
  endproperty
  a_event: assert property (p_event) else $error("Event not counted.");
  property p_t2inc;
    t2sys && t2 != 16'hFFFF |=> t2 == $past(t2) + 16'h1;
  endproperty
  a_t2inc: assert property (p_t2inc) else $error("Timer 2 missed a clock.");
  property p_t2reload;
    t2sys && t2 == 16'hFFFF && !load_reload_23[0] |=> t2 == reload_23[15:0];
  endproperty
  a_t2reload: assert property (p_t2reload) else $error("Timer 2 bad reload.");

  c_wrap: cover property (overflow_0);
  c_event: cover property ($fell(event_input_0) && counter_select_0);
  c_t2reload: cover property (t2sys && t2 == 16'hFFFF);
endmodule : fct_checker
`default_nettype wire

// [verification/fct_pulse_src.sv]
/*
  Model of an external event source: a pin, comparator or slow clock.
  Assumes the caller runs bursts from the bench clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fct_pulse_src (
  input wire logic core_clk,
  output logic level
);
  // The line idles high between bursts.
  initial level = 1'b1;

  // Sends n falling edges, each level held for hold clock periods.
  task automatic burst(input int n, input int hold);
    repeat (n) begin
      repeat (hold) @(posedge core_clk);
      #1 level = 1'b0;
      repeat (hold) @(posedge core_clk);
      #1 level = 1'b1;
    end
  endtask : burst
endmodule : fct_pulse_src
`default_nettype wire

// [verification/four_counter_timer_set_bench.sv]
/*
  Self-checking bench for the four counter/timer set.
  Assumes the timer ports, the checker and the pulse source model.
*/
`timescale 1ns/1ps
`default_nettype none
module four_counter_timer_set_bench;
  logic core_clk, srst;
  logic [1:0] prescale_select, mode_0, mode_1, run_control_hi, run_control_23, split_23;
  logic [1:0] capture_23, sysclk_lo_23, sysclk_hi_23, load_23, load_reload_23;
  logic timer0_clock_select, timer1_clock_select, counter_select_0, counter_select_1;
  logic run_control_0, run_control_1, gate_enable_0, gate_enable_1, load_0, load_1;
  logic external_gate_input_0, external_gate_input_1, rtc_clk, comparator_1;
  logic event_input_0, event_input_1, ext_osc_clk, comparator_0;
  logic [15:0] load_value_0, load_value_1, count_0, count_1;
  logic [3:0] xclk_23;
  logic [31:0] load_count_23, reload_value_23, count_23, reload_23;
  logic overflow_0, overflow_1;
  logic [1:0] overflow_lo_23, overflow_hi_23;
  logic [1:0] sel [3];
  int ratio [3];
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  fct_timers i_fct_timers (.*);
  fct_pulse_src i_src_ev0 (.core_clk(core_clk), .level(event_input_0));
  fct_pulse_src i_src_ev1 (.core_clk(core_clk), .level(event_input_1));
  fct_pulse_src i_src_osc (.core_clk(core_clk), .level(ext_osc_clk));
  fct_pulse_src i_src_cmp (.core_clk(core_clk), .level(comparator_0));
  fct_pulse_src i_src_rtc (.core_clk(core_clk), .level(rtc_clk));
  fct_pulse_src i_src_cmp1 (.core_clk(core_clk), .level(comparator_1));

  // Clock at 25 MHz.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Cuts a hung run short.
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic ld0(input logic [15:0] v);
    load_value_0 = v;
    load_0 = 1'b1;
    cyc(1);
    load_0 = 1'b0;
  endtask : ld0

  task automatic run0(input int n);
    run_control_0 = 1'b1;
    cyc(n);
    run_control_0 = 1'b0;
  endtask : run0

  // Main sequence: reset, Timers 0 and 1, then Timers 2 and 3.
  initial begin
    srst = 1'b1;
    {prescale_select, mode_0, mode_1, run_control_hi, run_control_23, split_23} = '0;
    {capture_23, sysclk_lo_23, sysclk_hi_23, load_23, load_reload_23, xclk_23} = '0;
    {timer0_clock_select, timer1_clock_select, counter_select_0, counter_select_1} = '0;
    {run_control_0, run_control_1, gate_enable_0, gate_enable_1, load_0, load_1} = '0;
    {external_gate_input_0, external_gate_input_1} = 2'h0;
    {load_value_0, load_value_1, load_count_23, reload_value_23} = '0;
    cyc(3);
    srst = 1'b0;
    mode_0 = fct_pkg::MODE_16BIT;
    timer0_clock_select = 1'b1;
    ld0(16'h1234);
    run0(10);
    chk("count_0 sysclk", 32'h123E, count_0);
    gate_enable_0 = 1'b1;
    run0(5);
    chk("count_0 gated", 32'h123E, count_0);
    external_gate_input_0 = 1'b1;
    run0(4);
    chk("count_0 ungated", 32'h1242, count_0);
    gate_enable_0 = 1'b0;
    mode_0 = fct_pkg::MODE_13BIT;
    ld0(16'hFFFF);
    run0(1);
    chk("count_0 wrap", 32'h00E0, count_0);
    chk("overflow_0", 32'h1, overflow_0);
    cyc(1);
    chk("overflow_0 pulse", 32'h0, overflow_0);
    mode_0 = fct_pkg::MODE_8BIT_RELOAD;
    ld0(16'h80FE);
    run0(3);
    chk("count_0 reload", 32'h8081, count_0);
    {mode_0, mode_1} = {fct_pkg::MODE_SPLIT, fct_pkg::MODE_SPLIT};
    {timer1_clock_select, run_control_1} = 2'h3;
    ld0(16'hFF00);
    run0(4);
    run_control_hi = 2'h1;
    cyc(1);
    chk("overflow_1 split", 32'h1, overflow_1);
    cyc(2);
    run_control_hi = 2'h0;
    chk("count_0 split", 32'h0204, count_0);
    chk("count_1 split", 32'h0, count_1);
    // Event counting at a quarter (Timer 0) and a sixth (Timer 1) of the clock rate; the clock select is ignored.
    {mode_0, mode_1} = {fct_pkg::MODE_16BIT, fct_pkg::MODE_16BIT};
    {counter_select_0, counter_select_1, timer0_clock_select} = 3'h6;
    {load_value_1, load_1} = {16'h0100, 1'b1};
    ld0(16'h0000);
    load_1 = 1'b0;
    run_control_0 = 1'b1;
    fork
      i_src_ev0.burst(5, 2);
      i_src_ev1.burst(7, 3);
    join
    cyc(5);
    {run_control_0, run_control_1, counter_select_0, counter_select_1} = '0;
    chk("count_0 events", 32'h5, count_0);
    chk("count_1 events", 32'h0107, count_1);
    // Prescaled clocks: a window of eight periods holds exactly eight ticks.
    sel = '{fct_pkg::PRESCALE_DIV12, fct_pkg::PRESCALE_DIV48, fct_pkg::PRESCALE_DIV4};
    ratio = '{12, 48, 4};
    for (int i = 0; i < 3; i++) begin
      prescale_select = sel[i];
      cyc(100);
      ld0(16'h0000);
      run0(8 * ratio[i]);
      chk("count_0 prescaled", 32'h8, count_0);
    end
    prescale_select = fct_pkg::PRESCALE_EXT8;
    ld0(16'h0000);
    run_control_0 = 1'b1;
    i_src_osc.burst(24, 2);
    cyc(5);
    run_control_0 = 1'b0;
    chk("count_0 ext clock", 32'h3, count_0);
    // Timer 2 in 16-bit reload, Timer 3 split, both on the system clock.
    {load_count_23, reload_value_23} = {32'hFFFEFFFE, 32'h2030FFF0};
    {load_23, load_reload_23} = 4'hF;
    cyc(1);
    {load_23, load_reload_23, split_23, sysclk_lo_23, sysclk_hi_23} = 10'h02F;
    run_control_23 = 2'h3;
    cyc(2);
    chk("overflow_lo_23 wrap", 32'h2, overflow_lo_23);
    chk("overflow_hi_23 wrap", 32'h1, overflow_hi_23);
    cyc(2);
    run_control_23 = 2'h0;
    chk("count_23 sysclk", 32'h2332FFF2, count_23);
    // Slow clocks: comparator for Timer 2, oscillator over eight for Timer 3.
    {sysclk_lo_23, sysclk_hi_23, split_23, load_count_23} = '0;
    xclk_23 = {fct_pkg::XCLK_SLOW8, fct_pkg::XCLK_CMP};
    load_23 = 2'h3;
    cyc(1);
    {load_23, run_control_23} = 4'h3;
    fork
      i_src_cmp.burst(6, 2);
      i_src_osc.burst(16, 2);
    join
    cyc(5);
    run_control_23 = 2'h0;
    chk("count_23 slow", 32'h00020006, count_23);
    xclk_23 = '0;
    load_23 = 2'h3;
    cyc(1);
    {load_23, run_control_23} = 4'h3;
    cyc(60);
    run_control_23 = 2'h0;
    chk("count_23 div12", 32'h00050005, count_23);
    // Real-time clock over eight for Timer 2, comparator 1 for Timer 3.
    xclk_23 = {fct_pkg::XCLK_CMP, fct_pkg::XCLK_SLOW8};
    load_23 = 2'h3;
    cyc(1);
    {load_23, run_control_23} = 4'h3;
    fork
      i_src_rtc.burst(16, 2);
      i_src_cmp1.burst(5, 2);
    join
    cyc(5);
    chk("count_23 rtc cmp1", 32'h00050002, count_23);
    // Capture: Timer 2 counts system clocks and latches them on the eighth slow edge.
    {capture_23, sysclk_lo_23, run_control_23, load_23} = 8'h57;
    cyc(1);
    load_23 = 2'h0;
    i_src_rtc.burst(8, 2);
    cyc(1);
    chk("reload_23 capture", 32'h20300020, reload_23);
    chk("count_23 capture", 32'h00000021, count_23);
    chk("overflow_hi_23 capture", 32'h1, overflow_hi_23);
    cyc(1);
    chk("overflow_hi_23 pulse", 32'h0, overflow_hi_23);
    stop_test();
  end
endmodule : four_counter_timer_set_bench

bind fct_timers fct_checker i_fct_checker (.*);
`default_nettype wire
